/* File: rtl/ocs_defs.svh */
// register map, field positions, reset values and timing counts
`ifndef OCS_DEFS_SVH
`define OCS_DEFS_SVH

// ----------------------------------------------------------------
// register offsets and fields
// ----------------------------------------------------------------
`define OCS_ADDR_STATUS  8'h41
`define OCS_ADDR_CMD     8'h42
`define OCS_ST_BUSY      7
`define OCS_ST_VENDOR    6
`define OCS_ST_OPT_B     2
`define OCS_ST_OPT_A     1
`define OCS_ST_REQ       0
`define OCS_CMD_TMR_HI   7
`define OCS_CMD_TMR_LO   5
`define OCS_CMD_HI       4
`define OCS_RST_TMR      3'h1
`define OCS_RST_CMD      5'h00

// ----------------------------------------------------------------
// command field codes
// ----------------------------------------------------------------
`define OCS_CODE_INQ     5'h01
`define OCS_CODE_LSTART  5'h02
`define OCS_CODE_LSTOP   5'h04
`define OCS_CODE_REMOTE  5'h08
`define OCS_CODE_IND     5'h10

// ----------------------------------------------------------------
// timer-delay intervals (20 MHz clock)
// ----------------------------------------------------------------
`define OCS_CLK_MHZ      32'h0000_0014
`define OCS_US_PER_MS    32'h0000_03E8
`define OCS_T1_US        32'h0000_0020
`define OCS_T2_US        32'h0000_0080
`define OCS_T3_US        32'h0000_0100
`define OCS_T4_US        32'h0000_0200
`define OCS_T5_MS        32'h0000_0001
`define OCS_T6_MS        32'h0000_0002
`define OCS_T7_MS        32'h0000_0004
`define OCS_T1_CYC  (`OCS_T1_US * `OCS_CLK_MHZ)
`define OCS_T2_CYC  (`OCS_T2_US * `OCS_CLK_MHZ)
`define OCS_T3_CYC  (`OCS_T3_US * `OCS_CLK_MHZ)
`define OCS_T4_CYC  (`OCS_T4_US * `OCS_CLK_MHZ)
`define OCS_T5_CYC  (`OCS_T5_MS * `OCS_US_PER_MS * `OCS_CLK_MHZ)
`define OCS_T6_CYC  (`OCS_T6_MS * `OCS_US_PER_MS * `OCS_CLK_MHZ)
`define OCS_T7_CYC  (`OCS_T7_MS * `OCS_US_PER_MS * `OCS_CLK_MHZ)

`endif

/* File: rtl/ocs_pkg.sv */
// types shared by the center-side command and status block
package ocs_pkg;

    typedef enum logic [2:0] {
        FR_NONE       = 3'b000,
        FR_INQUIRY    = 3'b001,
        FR_LOOP_START = 3'b010,
        FR_LOOP_STOP  = 3'b011,
        FR_REMOTE     = 3'b100,
        FR_INDICATE   = 3'b101
    } ocs_frame_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SEND  = 2'b01,
        ST_REPLY = 2'b10
    } ocs_state_e;

    typedef logic [16:0] ocs_count_t;

endpackage

/* File: rtl/ocs_tmr_if.sv */
// link between the command logic and its reply timeout timer
`timescale 1ns/1ps
interface ocs_tmr_if;
    logic       start;
    logic       cancel;
    logic [2:0] sel;
    logic       expire;

    modport ctl (
        output start,
        output cancel,
        output sel,
        input  expire
    );
    modport tmr (
        input  start,
        input  cancel,
        input  sel,
        output expire
    );
endinterface

/* File: rtl/ocs_sync.sv */
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module ocs_sync (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic d,
    output logic      q
);
    logic meta;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta <= 1'b0;
            q    <= 1'b0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

/* File: rtl/ocs_timer.sv */
// reply timeout timer with selectable interval
`timescale 1ns/1ps
`include "ocs_defs.svh"
module ocs_timer #(
    parameter logic [16:0] T3_CYC = 17'(`OCS_T3_CYC),
    parameter logic [16:0] T4_CYC = 17'(`OCS_T4_CYC),
    parameter logic [16:0] T5_CYC = 17'(`OCS_T5_CYC),
    parameter logic [16:0] T6_CYC = 17'(`OCS_T6_CYC),
    parameter logic [16:0] T7_CYC = 17'(`OCS_T7_CYC)
) (
    input  wire logic clk,
    input  wire logic nrst,
    ocs_tmr_if.tmr    tif
);
    import ocs_pkg::*;

    localparam ocs_count_t T1_CYC = 17'(`OCS_T1_CYC);
    localparam ocs_count_t T2_CYC = 17'(`OCS_T2_CYC);

    ocs_count_t sel_cyc;
    ocs_count_t limit;
    ocs_count_t count;
    logic       running;
    wire        hit;

    // reserved code 000 falls back to the shortest interval
    assign sel_cyc = (tif.sel == 3'h2) ? T2_CYC :
                     (tif.sel == 3'h3) ? T3_CYC :
                     (tif.sel == 3'h4) ? T4_CYC :
                     (tif.sel == 3'h5) ? T5_CYC :
                     (tif.sel == 3'h6) ? T6_CYC :
                     (tif.sel == 3'h7) ? T7_CYC : T1_CYC;
    assign hit        = running && (count == limit - 17'h0_0001);
    assign tif.expire = hit;

    // interval is latched at start so a rewrite cannot stretch a wait
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            running <= 1'b0;
            count   <= '0;
            limit   <= '0;
        end else if (tif.start) begin
            running <= 1'b1;
            count   <= '0;
            limit   <= sel_cyc;
        end else if (tif.cancel || hit) begin
            running <= 1'b0;
            count   <= '0;
        end else if (running) begin
            count <= count + 17'h0_0001;
        end
    end
endmodule

/* File: rtl/ocs_center.sv */
// center-side maintenance command and status register pair
//
// Functional notes
// - busy reads one during loop-back or while a reply/timeout is awaited
// - vendor bit zero selects special vendor compare mode, one normal mode
// - option b set clears terminal status six to ten on far side
// - option a set suppresses the center condition indication frame
// - request flag sets on watched register change, clears after read
// - timer field picks 32us..4ms, reset 001; code 000 must not be used
// - codes: none, condition inquiry, loop start, loop stop
// - code 01000 sends inquiry frame with model info from remote registers
// - indication frame goes automatically and also on code 10000
// - all frames except indication only originate in center-side mode
`timescale 1ns/1ps
`include "ocs_defs.svh"
module ocs_center #(
    parameter logic [16:0] T3_CYC = 17'(`OCS_T3_CYC),
    parameter logic [16:0] T4_CYC = 17'(`OCS_T4_CYC),
    parameter logic [16:0] T5_CYC = 17'(`OCS_T5_CYC),
    parameter logic [16:0] T6_CYC = 17'(`OCS_T6_CYC),
    parameter logic [16:0] T7_CYC = 17'(`OCS_T7_CYC)
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic [7:0]    reg_addr,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    input  wire logic [7:0]    reg_wdata,
    output logic [7:0]         reg_rdata,
    input  wire logic          converter_side_strap_hi,
    input  wire logic          converter_side_strap_lo,
    input  wire logic          fiber_addr_set,
    input  wire logic          watched_change,
    input  wire logic          loop_running,
    input  wire logic          auto_indicate,
    input  wire logic          reply_rx,
    output logic               frame_req,
    output ocs_pkg::ocs_frame_e frame_kind,
    input  wire logic          frame_ack,
    output logic               model_info_from_remote,
    output logic               special_vendor_mode,
    output logic               clear_terminal_status
);
    import ocs_pkg::*;

    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    ocs_state_e state;
    ocs_state_e next_state;
    ocs_frame_e next_kind;
    logic       vendor_mode;
    logic       option_b;
    logic       option_a;
    logic       req_flag;
    logic [2:0] timer_delay;
    logic [4:0] cmd_field;
    logic       auto_pend;
    logic       strap_hi_s;
    logic       strap_lo_s;

    ocs_tmr_if tif ();

    // ------------------------------------------------------------
    // strap synchronisers
    // ------------------------------------------------------------
    ocs_sync u_sync_hi (
        .clk  (clk),
        .nrst (nrst),
        .d    (converter_side_strap_hi),
        .q    (strap_hi_s)
    );

    ocs_sync u_sync_lo (
        .clk  (clk),
        .nrst (nrst),
        .d    (converter_side_strap_lo),
        .q    (strap_lo_s)
    );

    // ------------------------------------------------------------
    // reply timeout timer
    // ------------------------------------------------------------
    ocs_timer #(
        .T3_CYC (T3_CYC),
        .T4_CYC (T4_CYC),
        .T5_CYC (T5_CYC),
        .T6_CYC (T6_CYC),
        .T7_CYC (T7_CYC)
    ) u_timer (
        .clk  (clk),
        .nrst (nrst),
        .tif  (tif)
    );

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire       sel_status  = (reg_addr == `OCS_ADDR_STATUS);
    wire       sel_cmd     = (reg_addr == `OCS_ADDR_CMD);
    wire       wr_status   = reg_wr && sel_status;
    wire       wr_cmd      = reg_wr && sel_cmd;
    wire       rd_status   = reg_rd && sel_status;
    wire [4:0] wr_code     = reg_wdata[`OCS_CMD_HI:0];
    wire [2:0] wr_tmr      = reg_wdata[`OCS_CMD_TMR_HI:`OCS_CMD_TMR_LO];
    wire       wr_vendor   = reg_wdata[`OCS_ST_VENDOR];
    wire       wr_opt_b    = reg_wdata[`OCS_ST_OPT_B];
    wire       wr_opt_a    = reg_wdata[`OCS_ST_OPT_A];

    // center mode: straps 0,1 and the fiber address written
    wire       center_mode = !strap_hi_s && strap_lo_s
                             && fiber_addr_set;

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    // unlisted codes decode to no frame at all
    wire ocs_frame_e code_kind =
        (wr_code == `OCS_CODE_INQ)    ? FR_INQUIRY    :
        (wr_code == `OCS_CODE_LSTART) ? FR_LOOP_START :
        (wr_code == `OCS_CODE_LSTOP)  ? FR_LOOP_STOP  :
        (wr_code == `OCS_CODE_REMOTE) ? FR_REMOTE     :
        (wr_code == `OCS_CODE_IND)    ? FR_INDICATE   :
                                        FR_NONE;

    // only indication may leave a non-center converter
    wire kind_center_ok = (code_kind == FR_INDICATE) || center_mode;
    wire kind_opt_ok    = (code_kind != FR_INDICATE) || !option_a;
    wire cmd_allowed    = (code_kind != FR_NONE) && kind_center_ok
                          && kind_opt_ok;

    // writes to the command field are only taken while idle
    wire cmd_take       = wr_cmd && (state == ST_IDLE);
    wire cmd_launch     = cmd_take && cmd_allowed;
    wire auto_launch    = (state == ST_IDLE) && !cmd_launch && auto_pend;

    wire kind_wants_reply = (frame_kind == FR_INQUIRY)
                            || (frame_kind == FR_REMOTE);
    wire sent           = (state == ST_SEND) && frame_ack;

    // ------------------------------------------------------------
    // frame sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_kind  = frame_kind;
        unique case (state)
            ST_IDLE: begin
                if (cmd_launch) begin
                    next_state = ST_SEND;
                    next_kind  = code_kind;
                end else if (auto_launch) begin
                    next_state = ST_SEND;
                    next_kind  = FR_INDICATE;
                end
            end
            ST_SEND: begin
                if (frame_ack) begin
                    next_state = kind_wants_reply ? ST_REPLY : ST_IDLE;
                end
            end
            ST_REPLY: begin
                if (reply_rx || tif.expire) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state      <= ST_IDLE;
            frame_kind <= FR_NONE;
        end else begin
            state      <= next_state;
            frame_kind <= next_kind;
        end
    end

    // remote command reuses the inquiry layout with other model bytes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            model_info_from_remote <= 1'b0;
        end else begin
            model_info_from_remote <= (next_kind == FR_REMOTE);
        end
    end

    assign frame_req  = (state == ST_SEND);

    // timeout runs from the moment the frame has gone out
    assign tif.start  = sent && kind_wants_reply;
    assign tif.cancel = (state == ST_REPLY) && reply_rx;
    assign tif.sel    = timer_delay;

    // ------------------------------------------------------------
    // automatic indication request
    // ------------------------------------------------------------
    // a new request in the cycle the indication is acked survives the clear
    wire auto_set   = auto_indicate && !option_a;
    wire auto_clr   = option_a
                      || (sent && frame_kind == FR_INDICATE);
    wire next_auto  = auto_set || (auto_pend && !auto_clr);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            auto_pend <= 1'b0;
        end else begin
            auto_pend <= next_auto;
        end
    end

    // ------------------------------------------------------------
    // status register
    // ------------------------------------------------------------
    // set beats the read clear so no change is lost
    wire next_req = watched_change || (req_flag && !rd_status);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            req_flag <= 1'b0;
        end else begin
            req_flag <= next_req;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vendor_mode <= 1'b0;
            option_b    <= 1'b0;
            option_a    <= 1'b0;
        end else if (wr_status) begin
            vendor_mode <= wr_vendor;
            option_b    <= wr_opt_b;
            option_a    <= wr_opt_a;
        end
    end

    // busy covers the send of a reply-bearing frame as well
    wire wait_reply = (state == ST_REPLY);
    wire send_reply = frame_req && kind_wants_reply;
    wire busy       = loop_running || wait_reply || send_reply;

    assign clear_terminal_status = option_b;

    // ------------------------------------------------------------
    // far-side mode output
    // ------------------------------------------------------------
    // own flop so the inverted level leaves the block straight from a flop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            special_vendor_mode <= 1'b1;
        end else if (wr_status) begin
            special_vendor_mode <= !wr_vendor;
        end
    end

    // ------------------------------------------------------------
    // command register
    // ------------------------------------------------------------
    // refused codes read back as zero so software sees the refusal
    // timer code 000 is kept as written; the timer runs it as 001
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            timer_delay <= `OCS_RST_TMR;
            cmd_field   <= `OCS_RST_CMD;
        end else begin
            if (wr_cmd) begin
                timer_delay <= wr_tmr;
            end
            if (cmd_take) begin
                cmd_field <= cmd_allowed ? wr_code : `OCS_RST_CMD;
            end else if (sent) begin
                cmd_field <= `OCS_RST_CMD;
            end
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    // reserved bits 5 to 3 ignore writes and read as zero
    wire [7:0] status_word = {busy, vendor_mode, 3'h0,
                              option_b, option_a, req_flag};
    wire [7:0] cmd_word    = {timer_delay, cmd_field};
    // unmapped offsets read as zero
    wire [7:0] rd_word     = sel_status ? status_word :
                             sel_cmd    ? cmd_word    : 8'h00;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_word;
        end
    end
endmodule

/* File: verif/ocs_xmit_model.sv */
// transmitter model: takes queued frames, answers inquiries with a reply
`timescale 1ns/1ps
module ocs_xmit_model (
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire logic                frame_req,
    input  wire ocs_pkg::ocs_frame_e frame_kind,
    input  wire logic                reply_en,
    output logic                     frame_ack,
    output logic                     reply_rx
);
    import ocs_pkg::*;
    logic [3:0] wait_cnt;
    logic [3:0] reply_cnt;
    // --------------------------------------------------------------
    // slow ack so that frame_req has to hold for several cycles
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            frame_ack <= 1'b0;
            reply_rx  <= 1'b0;
            wait_cnt  <= 4'h0;
            reply_cnt <= 4'h0;
        end else begin
            frame_ack <= 1'b0;
            reply_rx  <= (reply_cnt == 4'h1);
            if (frame_req && !frame_ack) begin
                wait_cnt  <= wait_cnt + 4'h1;
                frame_ack <= (wait_cnt == 4'h3);
            end else begin
                wait_cnt <= 4'h0;
            end
            if (frame_ack && reply_en && (frame_kind == FR_INQUIRY ||
                frame_kind == FR_REMOTE)) begin
                reply_cnt <= 4'h8;
            end else if (reply_cnt != 4'h0) begin
                reply_cnt <= reply_cnt - 4'h1;
            end
        end
    end
endmodule

/* File: verif/ocs_center_chk.sv */
// concurrent checks on the ports of the center-side command block
`timescale 1ns/1ps
`include "ocs_defs.svh"
module ocs_center_chk #(
    parameter logic [16:0] T3_CYC = 17'h0_0014,
    parameter logic [16:0] T4_CYC = 17'h0_0018,
    parameter logic [16:0] T5_CYC = 17'h0_001c,
    parameter logic [16:0] T6_CYC = 17'h0_0020,
    parameter logic [16:0] T7_CYC = 17'h0_0024
) (
    input wire logic                clk,
    input wire logic                nrst,
    input wire logic [7:0]          reg_addr,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [7:0]          reg_wdata,
    input wire logic [7:0]          reg_rdata,
    input wire logic                watched_change,
    input wire logic                loop_running,
    input wire logic                auto_indicate,
    input wire logic                frame_req,
    input wire ocs_pkg::ocs_frame_e frame_kind,
    input wire logic                frame_ack,
    input wire logic                model_info_from_remote,
    input wire logic                special_vendor_mode,
    input wire logic                clear_terminal_status
);
    import ocs_pkg::*;
    logic st_rd;
    logic cmd_wr;
    assign st_rd  = reg_rd && reg_addr == `OCS_ADDR_STATUS;
    assign cmd_wr = reg_wr && reg_addr == `OCS_ADDR_CMD && !frame_req;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_busy_loop: assert property (
        st_rd && loop_running |=> reg_rdata[7])
        else $error("busy low during loop");
    chk_req_set: assert property (
        watched_change ##1 st_rd |=> reg_rdata[0])
        else $error("request flag not set");
    chk_req_clear: assert property (
        (st_rd && !watched_change) ##1 (!watched_change && !st_rd)
        ##1 (st_rd && !watched_change) |=> !reg_rdata[0])
        else $error("request flag not cleared by read");
    chk_vendor_mode: assert property (
        st_rd |=> reg_rdata[6] == !special_vendor_mode)
        else $error("vendor mode output wrong");
    chk_opt_b: assert property (
        st_rd |=> reg_rdata[2] == clear_terminal_status)
        else $error("terminal clear output wrong");
    chk_unlisted_code: assert property (
        cmd_wr && !auto_indicate && !(reg_wdata[4:0] inside
        {5'h01, 5'h02, 5'h04, 5'h08, 5'h10}) |=> !frame_req)
        else $error("frame sent for unlisted code");
    chk_inq_kind: assert property (
        cmd_wr && reg_wdata[4:0] == 5'h01
        |=> !frame_req || frame_kind == FR_INQUIRY)
        else $error("wrong kind for inquiry");
    chk_ind_kind: assert property (
        cmd_wr && reg_wdata[4:0] == 5'h10
        |=> !frame_req || frame_kind == FR_INDICATE)
        else $error("wrong kind for indication");
    chk_ack_drop: assert property (
        frame_req && frame_ack |=> !frame_req)
        else $error("frame request held after ack");
    chk_req_hold: assert property (
        frame_req && !frame_ack |=> frame_req && $stable(frame_kind))
        else $error("frame request dropped early");
    chk_remote_info: assert property (
        frame_req && frame_kind == FR_REMOTE |-> model_info_from_remote)
        else $error("remote frame without model info select");
endmodule

bind ocs_center ocs_center_chk #(
    .T3_CYC(T3_CYC), .T4_CYC(T4_CYC), .T5_CYC(T5_CYC),
    .T6_CYC(T6_CYC), .T7_CYC(T7_CYC)
) i_chk (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .watched_change(watched_change), .loop_running(loop_running),
    .auto_indicate(auto_indicate), .frame_req(frame_req),
    .frame_kind(frame_kind), .frame_ack(frame_ack),
    .model_info_from_remote(model_info_from_remote),
    .special_vendor_mode(special_vendor_mode),
    .clear_terminal_status(clear_terminal_status)
);

/* File: verif/ocs_center_tb.sv */
// register-level testbench for the center-side command block
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module ocs_center_tb;
    import ocs_pkg::*;
    logic clk = 1'b0;
    logic nrst, reg_wr, reg_rd, hi_strap, lo_strap, fiber_set;
    logic watched_change, loop_running, auto_indicate, reply_rx;
    logic frame_req, frame_ack, remote_info, vendor_mode, term_clear;
    logic reply_en;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    ocs_frame_e frame_kind;
    int errors = 0;
    int n_checks = 0;
    logic [4:0] code_tab [5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
    ocs_frame_e kind_tab [5] = '{FR_INQUIRY, FR_LOOP_START,
        FR_LOOP_STOP, FR_REMOTE, FR_INDICATE};

    always #25 clk = ~clk;

    // short reply intervals keep the timeout case quick
    ocs_center #(.T3_CYC(17'h0_0014), .T4_CYC(17'h0_0018),
        .T5_CYC(17'h0_001c), .T6_CYC(17'h0_0020), .T7_CYC(17'h0_0024)
    ) i_dut (
        .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .converter_side_strap_hi(hi_strap),
        .converter_side_strap_lo(lo_strap), .fiber_addr_set(fiber_set),
        .watched_change(watched_change), .loop_running(loop_running),
        .auto_indicate(auto_indicate), .reply_rx(reply_rx),
        .frame_req(frame_req), .frame_kind(frame_kind),
        .frame_ack(frame_ack), .model_info_from_remote(remote_info),
        .special_vendor_mode(vendor_mode),
        .clear_terminal_status(term_clear)
    );
    ocs_xmit_model i_xmit (.clk(clk), .nrst(nrst), .frame_req(frame_req),
        .frame_kind(frame_kind), .reply_en(reply_en),
        .frame_ack(frame_ack), .reply_rx(reply_rx));

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask

    task automatic wait_taken;
        int n;
        n = 0;
        while (frame_req !== 1'b0 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(frame_req, 1'b0)
    endtask

    // none means no frame must go out and the code field read back zero; the timer field keeps the written value
    task automatic send(input logic [7:0] cmd, input ocs_frame_e kind);
        wr(8'h42, cmd);
        #1;
        if (kind == FR_NONE) begin
            repeat (3) @(posedge clk);
            #1;
            `CHK(frame_req, 1'b0)
        end else begin
            `CHK({frame_req, frame_kind}, {1'b1, kind})
            `CHK(remote_info, kind == FR_REMOTE)
            wait_taken();
        end
        rd(8'h42, {cmd[7:5], 5'h00});
        if (kind != FR_NONE) begin
            rd(8'h41, {kind == FR_INQUIRY || kind == FR_REMOTE, 7'h00});
        end
    endtask

    task automatic pulse_auto;
        @(posedge clk);
        auto_indicate <= 1'b1;
        @(posedge clk);
        auto_indicate <= 1'b0;
        #1;
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        finish_test();
    end

    initial begin
        {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {watched_change, loop_running, auto_indicate, hi_strap} = '0;
        {lo_strap, fiber_set, reply_en} = 3'b111;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rd(8'h41, 8'h00);
        rd(8'h42, 8'h20);
        rd(8'h43, 8'h00);
        `CHK({vendor_mode, term_clear}, 2'b10)
        wr(8'h41, 8'hff);
        rd(8'h41, 8'h46);
        `CHK({vendor_mode, term_clear}, 2'b01)
        wr(8'h41, 8'h00);
        @(posedge clk);
        watched_change <= 1'b1;
        @(posedge clk);
        watched_change <= 1'b0;
        rd(8'h41, 8'h01);
        rd(8'h41, 8'h00);
        @(posedge clk);
        loop_running <= 1'b1;
        rd(8'h41, 8'h80);
        @(posedge clk);
        loop_running <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            send({3'h1, code_tab[i]}, kind_tab[i]);
            repeat (20) @(posedge clk);
            rd(8'h41, 8'h00);
        end
        send(8'h23, FR_NONE);
        send(8'h3f, FR_NONE);
        reply_en <= 1'b0;
        send(8'h61, FR_INQUIRY);
        repeat (9) @(posedge clk);
        rd(8'h41, 8'h80);
        repeat (12) @(posedge clk);
        rd(8'h41, 8'h00);
        reply_en <= 1'b1;
        wr(8'h41, 8'h02);
        send(8'h30, FR_NONE);
        pulse_auto();
        repeat (3) @(posedge clk);
        #1;
        `CHK(frame_req, 1'b0)
        wr(8'h41, 8'h00);
        pulse_auto();
        @(posedge clk);
        #1;
        `CHK({frame_req, frame_kind}, {1'b1, FR_INDICATE})
        wait_taken();
        @(posedge clk);
        fiber_set <= 1'b0;
        send(8'h21, FR_NONE);
        send(8'h30, FR_INDICATE);
        finish_test();
    end
endmodule
